// File: rtl/cptmr_top.sv
// compact timer: compare-match output, timer/counter and PWM modes on APB
module cptmr_top #(
	parameter int AW = cptmr_pkg::ADDR_W
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata_q,
	output logic pready_q,
	output logic pslverr_q,
	// timer output pin
	output logic pin_out_q,
	output logic pin_oe_q
);
	function automatic logic sel(input logic [AW-1:0] a, input logic [7:0] off);
		sel = (a == AW'(off));
	endfunction

	// register state
	cptmr_pkg::cptmr_ctrl_t ctrl_q;
	cptmr_pkg::cptmr_flags_t flags_q;
	cptmr_pkg::cptmr_flags_t flags_d;
	cptmr_pkg::cptmr_hits_t hits;
	logic on_q;
	logic on_prev_q;
	logic [cptmr_pkg::CNT_W-1:0] cmp_a_q;
	logic [cptmr_pkg::CMPP_W-1:0] cmp_p_q;
	logic [cptmr_pkg::DIV_W-1:0] div_q;
	logic [cptmr_pkg::CNT_W-1:0] cnt;
	logic tick;
	logic pin_lvl_q;
	logic pin_lvl_d;

	// bus decode
	wire acc = psel && penable && !pready_q;
	wire done = psel && penable && pready_q;
	wire wr = done && pwrite;
	wire s_en = sel(paddr, cptmr_pkg::OFF_ENABLE);
	wire s_ctl = sel(paddr, cptmr_pkg::OFF_CONTROL);
	wire s_cnt = sel(paddr, cptmr_pkg::OFF_COUNT);
	wire s_ca = sel(paddr, cptmr_pkg::OFF_CMP_A);
	wire s_cp = sel(paddr, cptmr_pkg::OFF_CMP_P);
	wire s_st = sel(paddr, cptmr_pkg::OFF_STATUS);
	wire s_div = sel(paddr, cptmr_pkg::OFF_PRESCALE);
	wire mapped = s_en || s_ctl || s_cnt || s_ca || s_cp || s_st || s_div;
	wire bad_wr = pwrite && s_cnt;
	wire err = !mapped || bad_wr;

	// sequencing
	wire on_rise = on_q && !on_prev_q;
	wire step = on_q && tick;
	wire is_cmp = (ctrl_q.mode == cptmr_pkg::MODE_CMP);
	wire is_pwm = (ctrl_q.mode == cptmr_pkg::MODE_PWM);
	wire drives = is_cmp || is_pwm;

	// pwm lengths
	wire [16:0] p_len = (cmp_p_q == '0) ? cptmr_pkg::FULL_SPAN :
		{1'b0, cmp_p_q, 8'h00};
	wire [16:0] a_val = {1'b0, cmp_a_q};
	wire [16:0] duty = ctrl_q.swap ? p_len : a_val;
	wire pwm_on = ({1'b0, cnt} < duty);
	wire pwm_lvl = pwm_on ? ctrl_q.init : !ctrl_q.init;

	// status write-one-to-clear
	wire clr_a = wr && s_st && pwdata[cptmr_pkg::ST_A_BIT];
	wire clr_p = wr && s_st && pwdata[cptmr_pkg::ST_P_BIT];

	// read mux
	wire [31:0] st_word = {29'h0, pin_lvl_q, flags_q.match_p, flags_q.match_a};
	wire [31:0] rd_mux =
		s_en ? {31'h0, on_q} :
		s_ctl ? {24'h0, ctrl_q} :
		s_cnt ? {16'h0, cnt} :
		s_ca ? {16'h0, cmp_a_q} :
		s_cp ? {24'h0, cmp_p_q} :
		s_st ? st_word :
		s_div ? {24'h0, div_q} : 32'h0;

	cptmr_prescaler #(
		.W(cptmr_pkg::DIV_W)
	) u_div (
		.pclk(pclk),
		.presetn(presetn),
		.run(on_q),
		.div(div_q),
		.tick_q(tick)
	);

	cptmr_counter #(
		.W(cptmr_pkg::CNT_W),
		.PW(cptmr_pkg::CMPP_W)
	) u_cnt (
		.pclk(pclk),
		.presetn(presetn),
		.restart(on_rise),
		.step(step),
		.ctrl(ctrl_q),
		.cmp_a(cmp_a_q),
		.cmp_p(cmp_p_q),
		.cnt_q(cnt),
		.hits(hits)
	);

	// flags: a new match wins over a clear in the same cycle
	always_comb begin
		flags_d.match_a = (flags_q.match_a && !clr_a) || hits.hit_a;
		flags_d.match_p = (flags_q.match_p && !clr_p) || hits.hit_p;
	end

	// pin level before inversion
	always_comb begin
		pin_lvl_d = pin_lvl_q;
		if (is_cmp) begin
			if (on_rise) begin
				pin_lvl_d = ctrl_q.init;
			end else if (hits.hit_a) begin
				case (ctrl_q.act)
					cptmr_pkg::ACT_LOW: pin_lvl_d = 1'b0;
					cptmr_pkg::ACT_HIGH: pin_lvl_d = 1'b1;
					cptmr_pkg::ACT_TOGGLE: pin_lvl_d = !pin_lvl_q;
					default: pin_lvl_d = pin_lvl_q;
				endcase
			end
		end else if (is_pwm && on_q) begin
			case (ctrl_q.act)
				cptmr_pkg::PWM_IDLE: pin_lvl_d = !ctrl_q.init;
				cptmr_pkg::PWM_ACTIVE: pin_lvl_d = ctrl_q.init;
				cptmr_pkg::PWM_PASS: pin_lvl_d = pwm_lvl;
				default: pin_lvl_d = !ctrl_q.init;
			endcase
		end
	end

	// apb handshake: one wait state, data and error ready with pready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end else begin
			pready_q <= acc;
			pslverr_q <= acc && err;
			prdata_q <= (acc && !pwrite) ? rd_mux : 32'h0;
		end
	end

	// software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			on_q <= 1'b0;
			ctrl_q <= cptmr_pkg::CTRL_RESET;
			cmp_a_q <= '0;
			cmp_p_q <= '0;
			div_q <= cptmr_pkg::DIV_RESET;
		end else if (wr) begin
			if (s_en) begin
				on_q <= pwdata[cptmr_pkg::EN_ON_BIT];
			end
			if (s_ctl) begin
				ctrl_q <= pwdata[7:0];
			end
			if (s_ca) begin
				cmp_a_q <= pwdata[cptmr_pkg::CNT_W-1:0];
			end
			if (s_cp) begin
				cmp_p_q <= pwdata[cptmr_pkg::CMPP_W-1:0];
			end
			if (s_div) begin
				div_q <= pwdata[cptmr_pkg::DIV_W-1:0];
			end
		end
	end

	// timer state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			on_prev_q <= 1'b0;
			flags_q <= '0;
			pin_lvl_q <= 1'b0;
		end else begin
			on_prev_q <= on_q;
			flags_q <= flags_d;
			pin_lvl_q <= pin_lvl_d;
		end
	end

	// pin drivers: timer/counter mode releases the pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_out_q <= 1'b0;
			pin_oe_q <= 1'b0;
		end else begin
			pin_out_q <= pin_lvl_d ^ ctrl_q.inv;
			pin_oe_q <= drives;
		end
	end

	// checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_restart;
		on_rise ##1 (cnt == '0);
	endsequence

	sequence s_off_hold;
		!on_q ##1 $stable(cnt);
	endsequence

	AST_RESTART_ZERO: assert property (on_rise |-> s_restart)
		else $error("counter not zeroed after enable rise");

	AST_OFF_HOLDS: assert property (!on_q && !on_rise |-> s_off_hold)
		else $error("counter moved while disabled");

	AST_RESTART_PIN: assert property (on_rise && is_cmp |=> pin_lvl_q == $past(ctrl_q.init))
		else $error("pin not at initial level after enable rise");

	AST_FLAG_SAME_TICK: assert property (hits.hit_a |=> flags_q.match_a)
		else $error("A flag missing after A match");

	AST_FLAG_STICKY: assert property (flags_q.match_p && !clr_p |=> flags_q.match_p)
		else $error("P flag dropped without a clear");

	AST_NO_P_CLR_A: assert property (!is_pwm && ctrl_q.clr_a && !flags_q.match_p |=> !flags_q.match_p)
		else $error("P flag raised while clearing on A");

	AST_A_ZERO_NOFLAG: assert property (cmp_a_q == '0 && !flags_q.match_a |=> !flags_q.match_a)
		else $error("A flag raised with zero A value");

	AST_PIN_ONLY_A: assert property (is_cmp && !hits.hit_a && !on_rise |=> $stable(pin_lvl_q))
		else $error("pin changed without an A match");

	AST_ACT_TOGGLE: assert property (is_cmp && hits.hit_a && !on_rise && ctrl_q.act == cptmr_pkg::ACT_TOGGLE
		|=> pin_lvl_q != $past(pin_lvl_q))
		else $error("toggle action did not toggle");

	AST_TMR_RELEASE: assert property (ctrl_q.mode == cptmr_pkg::MODE_TMR |=> !pin_oe_q)
		else $error("pin driven in timer/counter mode");

	AST_PWM_FULL: assert property (is_pwm && on_q && !ctrl_q.swap && ctrl_q.act == cptmr_pkg::PWM_PASS
		&& a_val >= p_len |=> pin_lvl_q == ctrl_q.init)
		else $error("full duty not held active");

	AST_PWM_RUNS_FORCED: assert property (is_pwm && step && ctrl_q.act == cptmr_pkg::PWM_IDLE && !on_rise
		|=> cnt != $past(cnt))
		else $error("PWM counter stopped while pin forced");

	AST_PWM_PIN_OUT: assert property (is_pwm && on_q |=> pin_out_q == (pin_lvl_q ^ ctrl_q.inv))
		else $error("pin output not inverted as set");

	AST_PERIOD_P: assert property (is_pwm && !ctrl_q.swap && step && cmp_p_q != '0
		&& cnt + 16'h0001 == {cmp_p_q, 8'h00} && !on_rise |=> cnt == '0 && flags_q.match_p)
		else $error("P period end did not clear and flag");

	AST_PERIOD_A: assert property (is_pwm && ctrl_q.swap && step && cmp_a_q != '0
		&& cnt + 16'h0001 == cmp_a_q && !on_rise |=> cnt == '0 && flags_q.match_a)
		else $error("A period end did not clear and flag");

	AST_CMP_P_CLEAR: assert property (is_cmp && !ctrl_q.clr_a && hits.hit_p && !on_rise
		|=> cnt == '0 ##0 flags_q.match_p)
		else $error("P match did not clear in compare mode");

	AST_APB_ONE_WAIT: assert property (psel && penable && !pready_q |=> pready_q)
		else $error("bus access not answered after one wait");
endmodule

// File: rtl/cptmr_pkg.sv
package cptmr_pkg;
	localparam int CNT_W = 16;
	localparam int CMPP_W = 8;
	localparam int DIV_W = 8;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_ENABLE = 8'h00;
	localparam logic [7:0] OFF_CONTROL = 8'h04;
	localparam logic [7:0] OFF_COUNT = 8'h08;
	localparam logic [7:0] OFF_CMP_A = 8'h0c;
	localparam logic [7:0] OFF_CMP_P = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;
	localparam logic [7:0] OFF_PRESCALE = 8'h18;
	localparam int EN_ON_BIT = 0;
	localparam int ST_A_BIT = 0;
	localparam int ST_P_BIT = 1;
	localparam int ST_PIN_BIT = 2;
	localparam logic [1:0] MODE_CMP = 2'h0;
	localparam logic [1:0] MODE_PWM = 2'h2;
	localparam logic [1:0] MODE_TMR = 2'h3;
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_LOW = 2'h1;
	localparam logic [1:0] ACT_HIGH = 2'h2;
	localparam logic [1:0] ACT_TOGGLE = 2'h3;
	localparam logic [1:0] PWM_IDLE = 2'h0;
	localparam logic [1:0] PWM_ACTIVE = 2'h1;
	localparam logic [1:0] PWM_PASS = 2'h2;
	localparam logic [16:0] FULL_SPAN = 17'h10000;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] DIV_RESET = 8'h00;
	typedef struct packed {
		logic [1:0] mode;
		logic [1:0] act;
		logic init;
		logic inv;
		logic swap;
		logic clr_a;
	} cptmr_ctrl_t;
	typedef struct packed {
		logic match_p;
		logic match_a;
	} cptmr_flags_t;
	typedef struct packed {
		logic hit_a;
		logic hit_p;
	} cptmr_hits_t;
endpackage

// File: rtl/cptmr_prescaler.sv
// timer clock enable: one pulse every div+1 bus clocks while run is high
module cptmr_prescaler #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic run,
	input wire logic [W-1:0] div,
	// timer clock enable
	output logic tick_q
);
	logic [W-1:0] cnt_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
			tick_q <= 1'b0;
		end else if (!run) begin
			cnt_q <= '0;
			tick_q <= 1'b0;
		end else if (cnt_q >= div) begin
			cnt_q <= '0;
			tick_q <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 1'b1;
			tick_q <= 1'b0;
		end
	end
endmodule

// File: rtl/cptmr_counter.sv
// 16-bit up-counter with comparators A and P and the clear selection
module cptmr_counter #(
	parameter int W = 16,
	parameter int PW = 8
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// sequencing
	input wire logic restart,
	input wire logic step,
	// settings
	input wire cptmr_pkg::cptmr_ctrl_t ctrl,
	input wire logic [W-1:0] cmp_a,
	input wire logic [PW-1:0] cmp_p,
	// state and events
	output logic [W-1:0] cnt_q,
	output cptmr_pkg::cptmr_hits_t hits
);
	logic [W-1:0] inc;
	logic ovf;
	logic a_raw;
	logic p_raw;
	logic pwm;
	logic clr;

	assign inc = cnt_q + 1'b1;
	assign ovf = (cnt_q == '1);
	assign pwm = (ctrl.mode == cptmr_pkg::MODE_PWM);
	// zero A never matches, so the counter wraps at ffff
	assign a_raw = step && (cmp_a != '0) && (inc == cmp_a);
	// P sees only the high byte, reached on a 256-clock boundary
	assign p_raw = step && ((cmp_p == '0) ? ovf :
		((inc[W-1 -: PW] == cmp_p) && (inc[W-PW-1:0] == '0)));
	assign hits.hit_a = a_raw;
	assign hits.hit_p = p_raw && (pwm || !ctrl.clr_a);
	assign clr = pwm ? (ctrl.swap ? a_raw : p_raw) :
		(ctrl.clr_a ? a_raw : p_raw);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
		end else if (restart) begin
			cnt_q <= '0;
		end else if (step) begin
			cnt_q <= clr ? '0 : inc;
		end
	end
endmodule

// File: testbench/cptmr_load.sv
// far-side load on the timer pin: counts cycles the pin is seen high
module cptmr_load (
	// clock and window control
	input wire logic pclk,
	input wire logic clr,
	// timer pin
	input wire logic pin_out,
	input wire logic pin_oe,
	// observation
	output logic [15:0] high_cnt
);
	timeunit 1ns;
	timeprecision 1ps;
	// pull-down holds the pin low while it is released
	wire logic level = pin_oe & pin_out;
	always @(posedge pclk) begin
		if (clr) begin
			high_cnt <= 16'h0000;
		end else if (level === 1'b1) begin
			high_cnt <= high_cnt + 16'h0001;
		end
	end
endmodule

// File: testbench/cptmr_tb_top.sv
module cptmr_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [31:0] e;
		logic [31:0] m;
		logic er;
	} cptmr_exp_t;
	typedef struct packed {
		logic [7:0] ctrl;
		logic [15:0] a;
		logic [7:0] p;
		logic [15:0] highs;
		logic [2:0] st;
		logic [2:0] m;
	} cptmr_case_t;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic pin_out_q;
	logic pin_oe_q;
	logic lc_clr = 1'b1;
	logic [15:0] high_cnt;
	int err_count = 0;
	int n_checks = 0;
	integer seed = 32'h58d83342;
	cptmr_exp_t q[$];
	cptmr_case_t cases [10] = '{
		{8'h21, 16'h0010, 8'h01, 16'h0200, 3'h5, 3'h7},
		{8'h08, 16'h0010, 8'h01, 16'h0200, 3'h7, 3'h7},
		{8'h21, 16'h0000, 8'h01, 16'h0000, 3'h0, 3'h7},
		{8'hc1, 16'h0010, 8'h01, 16'h0000, 3'h1, 3'h3},
		{8'ha9, 16'h0040, 8'h01, 16'h0080, 3'h3, 3'h3},
		{8'ha8, 16'h0200, 8'h01, 16'h0200, 3'h2, 3'h3},
		{8'hac, 16'h0200, 8'h01, 16'h0000, 3'h2, 3'h3},
		{8'haa, 16'h0100, 8'h00, 16'h0200, 3'h1, 3'h3},
		{8'h88, 16'h0040, 8'h01, 16'h0000, 3'h3, 3'h3},
		{8'h98, 16'h0040, 8'h01, 16'h0200, 3'h3, 3'h3}
	};

	always #2 pclk = ~pclk;

	cptmr_top i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
		.pslverr_q(pslverr_q), .pin_out_q(pin_out_q), .pin_oe_q(pin_oe_q)
	);

	cptmr_load i_load (
		.pclk(pclk), .clr(lc_clr), .pin_out(pin_out_q), .pin_oe(pin_oe_q), .high_cnt(high_cnt)
	);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string name);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s exp %h seen %h", name, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// one apb transfer; the expected answer is queued for the monitor
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
			input logic [31:0] e, input logic [31:0] m, input logic er);
		int i;
		q.push_back({e, m, er});
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		i = 0;
		while (pready_q !== 1'b1) begin
			@(posedge pclk);
			i++;
			if (i > 8) begin
				err_count++;
				end_sim();
			end
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, 32'h0, 32'hffffffff, 1'b0);
	endtask

	always @(posedge pclk) begin
		if (psel && penable && pready_q === 1'b1 && q.size() > 0) begin
			chk(prdata_q & q[0].m, q[0].e, "rdata");
			chk({31'h0, pslverr_q}, {31'h0, q[0].er}, "pslverr");
			void'(q.pop_front());
		end
	end

	initial begin
		logic [31:0] r;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		xfer(1'b0, cptmr_pkg::OFF_CONTROL, 32'h0, 32'h0, 32'hffffffff, 1'b0);
		xfer(1'b0, cptmr_pkg::OFF_CMP_A, 32'h0, 32'h0, 32'hffffffff, 1'b0);
		r = $random(seed);
		// unmapped addresses and the read-only count are refused
		xfer(1'b1, {2'h2, r[5:0]}, $random(seed), 32'h0, 32'hffffffff, 1'b1);
		xfer(1'b0, 8'h80 | {r[7:2], 2'h0}, 32'h0, 32'h0, 32'hffffffff, 1'b1);
		xfer(1'b1, cptmr_pkg::OFF_COUNT, $random(seed), 32'h0, 32'hffffffff, 1'b1);
		foreach (cases[k]) begin
			wr(cptmr_pkg::OFF_ENABLE, 32'h0);
			wr(cptmr_pkg::OFF_CONTROL, {24'h0, cases[k].ctrl});
			wr(cptmr_pkg::OFF_CMP_A, {16'h0, cases[k].a});
			wr(cptmr_pkg::OFF_CMP_P, {24'h0, cases[k].p});
			wr(cptmr_pkg::OFF_STATUS, 32'h3);
			wr(cptmr_pkg::OFF_ENABLE, 32'h1);
			repeat (300) @(posedge pclk);
			lc_clr <= 1'b1;
			@(posedge pclk);
			lc_clr <= 1'b0;
			repeat (512) @(posedge pclk);
			@(negedge pclk);
			chk({16'h0, high_cnt}, {16'h0, cases[k].highs}, "pin_high");
			@(posedge pclk);
			xfer(1'b0, cptmr_pkg::OFF_STATUS, 32'h0, {29'h0, cases[k].st}, {29'h0, cases[k].m}, 1'b0);
		end
		end_sim();
	end
endmodule
